// ==== verilog/windowed_watchdog_defines.svh ====
// register offsets, field positions, reset values and counts of the windowed watchdog
// assumes inclusion by bare name from the package and the watchdog module
`ifndef WINDOWED_WATCHDOG_DEFINES_SVH
`define WINDOWED_WATCHDOG_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define WINDOWED_WATCHDOG_OFS_CTRL0 4'h0
`define WINDOWED_WATCHDOG_OFS_CTRL1 4'h1
`define WINDOWED_WATCHDOG_OFS_STATUS 4'h2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WINDOWED_WATCHDOG_C0_SEN 0
`define WINDOWED_WATCHDOG_C0_PS_MSB 5
`define WINDOWED_WATCHDOG_C0_PS_LSB 1
`define WINDOWED_WATCHDOG_C1_WIN_MSB 2
`define WINDOWED_WATCHDOG_C1_WIN_LSB 0
`define WINDOWED_WATCHDOG_C1_CS_MSB 6
`define WINDOWED_WATCHDOG_C1_CS_LSB 4

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define WINDOWED_WATCHDOG_PS_DEFAULT 5'h0B
`define WINDOWED_WATCHDOG_PS_CFG_SW 5'h1F
`define WINDOWED_WATCHDOG_PS_MAX 5'h12
`define WINDOWED_WATCHDOG_PS_BASE 5'h05
`define WINDOWED_WATCHDOG_SEL_CFG_SW 3'h7
`define WINDOWED_WATCHDOG_CS_DEFAULT 3'h0
`define WINDOWED_WATCHDOG_CS_LF 3'h0
`define WINDOWED_WATCHDOG_CS_MF 3'h1
`define WINDOWED_WATCHDOG_CS_SECONDARY_OSC 3'h2
`define WINDOWED_WATCHDOG_WIN_OPEN 3'h7

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define WINDOWED_WATCHDOG_SECONDARY_OSC_STARTUP 1024
`define WINDOWED_WATCHDOG_CNT_W 23

`endif

// ==== verilog/windowed_watchdog_pkg.sv ====
// types shared by the windowed watchdog and its surroundings
// assumes the defines header sits beside it
`include "windowed_watchdog_defines.svh"

package windowed_watchdog_pkg;

    // ----------------------------------------------------------------
    // enable configuration modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        WINDOWED_WATCHDOG_MODE_OFF = 2'b00,   // always off
        WINDOWED_WATCHDOG_MODE_SW = 2'b01,    // software enable decides
        WINDOWED_WATCHDOG_MODE_NOSLP = 2'b10, // on while awake
        WINDOWED_WATCHDOG_MODE_ON = 2'b11     // always on
    } windowed_watchdog_mode_e;

    // configuration word fields, static while out of reset
    typedef struct packed {
        windowed_watchdog_mode_e enable_configuration;
        logic [4:0] config_period_select;
        logic [2:0] config_clock_select;
        logic [2:0] config_window_select;
    } windowed_watchdog_cfg_s;

    // sticky status flags toward the core
    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
        logic watchdog_reset_flag;
    } windowed_watchdog_flags_s;

endpackage : windowed_watchdog_pkg

// ==== verilog/windowed_watchdog_top.sv ====
// windowed watchdog: control registers, prescaled counter, window check, sleep handling
// assumes config words stable out of reset, oscillator levels asynchronous to sys_clk_i
`timescale 1ns/10ps
`include "windowed_watchdog_defines.svh"

module windowed_watchdog_top #(
    parameter int SECONDARY_OSC_STARTUP = `WINDOWED_WATCHDOG_SECONDARY_OSC_STARTUP, // secondary oscillator start-up edges
    parameter int CNT_W = `WINDOWED_WATCHDOG_CNT_W                // prescaled counter width
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire windowed_watchdog_pkg::windowed_watchdog_cfg_s cfg_i,
    input wire logic lfosc_clk_i,
    input wire logic mfosc_clk_i,
    input wire logic secondary_osc_clk_i,
    input wire logic sleep_i,
    input wire logic ost_running_i,
    input wire logic clear_watchdog_instruction_i,
    input wire logic flags_clear_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    output logic wdt_reset_o,
    output logic wake_o,
    output windowed_watchdog_pkg::windowed_watchdog_flags_s flags_o
);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // reserved prescale codes fall back to the shortest ratio
    function automatic logic [4:0] windowed_watchdog_eff_ps(input logic [4:0] ps);
        windowed_watchdog_eff_ps = (ps > `WINDOWED_WATCHDOG_PS_MAX) ? 5'h00 : ps;
    endfunction : windowed_watchdog_eff_ps

    // terminal count of the prescaled counter, ratio minus one
    function automatic logic [CNT_W-1:0] windowed_watchdog_term(input logic [4:0] ps);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        windowed_watchdog_term = (one << (windowed_watchdog_eff_ps(ps) + `WINDOWED_WATCHDOG_PS_BASE)) - one;
    endfunction : windowed_watchdog_term

    // five top bits of the current period, used for the window
    function automatic logic [4:0] windowed_watchdog_winval(input logic [CNT_W-1:0] cnt, input logic [4:0] ps);
        logic [CNT_W-1:0] sh;
        sh = cnt >> windowed_watchdog_eff_ps(ps);
        windowed_watchdog_winval = sh[4:0];
    endfunction : windowed_watchdog_winval

    // ----------------------------------------------------------------
    // oscillator synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [2:0] osc_meta;   // first stage, read by second stage only
    logic [2:0] osc_sync;   // second stage, safe to use
    logic [2:0] osc_prev;   // delayed copy for rising edges
    logic [2:0] osc_edge;   // one-cycle rise per oscillator

    // synchroniser chain, no logic between the stages
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_meta <= 3'h0;
            osc_sync <= 3'h0;
            osc_prev <= 3'h0;
        end else begin
            osc_meta <= {secondary_osc_clk_i, mfosc_clk_i, lfosc_clk_i};
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign osc_edge = osc_sync & ~osc_prev;

    // ----------------------------------------------------------------
    // secondary oscillator start-up gate
    // ----------------------------------------------------------------
    localparam int SW = $clog2(SECONDARY_OSC_STARTUP + 1);
    localparam logic [SW-1:0] SECONDARY_OSC_DONE = SW'(SECONDARY_OSC_STARTUP);
    logic [SW-1:0] secondary_osc_cnt;      // edges seen since reset
    logic [SW-1:0] next_secondary_osc_cnt;
    logic secondary_osc_ready;             // oscillator released to the watchdog

    // the oscillator restarts with any device reset, its clock withheld meanwhile
    always_comb begin
        next_secondary_osc_cnt = secondary_osc_cnt;
        if (osc_edge[2] && (secondary_osc_cnt != SECONDARY_OSC_DONE)) begin
            next_secondary_osc_cnt = secondary_osc_cnt + SW'(1);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            secondary_osc_cnt <= '0;
        end else begin
            secondary_osc_cnt <= next_secondary_osc_cnt;
        end
    end

    assign secondary_osc_ready = (secondary_osc_cnt == SECONDARY_OSC_DONE);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic loaded;             // config reset values taken
    logic [4:0] ps;           // prescale select
    logic software_enable;                // software enable
    logic [2:0] cs;           // clock select
    logic [2:0] win;          // window select
    logic armed;              // read of control zero seen
    logic next_loaded;
    logic [4:0] next_ps;
    logic next_sen;
    logic [2:0] next_cs;
    logic [2:0] next_win;
    logic next_armed;
    logic ps_sw;              // prescale writable
    logic cs_sw;              // clock select writable
    logic win_sw;             // window writable
    logic wr0;                // write to control zero
    logic wr1;                // write to control one
    logic rd0;                // read of control zero
    logic clr_evt;            // clear instruction seen while counting

    // address decode
    always_comb begin
        wr0 = 1'b0;
        wr1 = 1'b0;
        rd0 = 1'b0;
        if (reg_addr_i == `WINDOWED_WATCHDOG_OFS_CTRL0) begin
            wr0 = reg_we_i;
            rd0 = reg_re_i;
        end else if (reg_addr_i == `WINDOWED_WATCHDOG_OFS_CTRL1) begin
            wr1 = reg_we_i;
        end
    end

    assign ps_sw = (cfg_i.config_period_select == `WINDOWED_WATCHDOG_PS_CFG_SW);
    assign cs_sw = (cfg_i.config_clock_select == `WINDOWED_WATCHDOG_SEL_CFG_SW);
    assign win_sw = (cfg_i.config_window_select == `WINDOWED_WATCHDOG_SEL_CFG_SW);

    // register next values; config words are caught one edge after release
    always_comb begin
        next_loaded = 1'b1;
        next_ps = ps;
        next_sen = software_enable;
        next_cs = cs;
        next_win = win;
        next_armed = armed;
        if (!loaded) begin
            // reset values from the configuration words
            next_ps = ps_sw ? `WINDOWED_WATCHDOG_PS_DEFAULT : cfg_i.config_period_select;
            next_cs = cs_sw ? `WINDOWED_WATCHDOG_CS_DEFAULT : cfg_i.config_clock_select;
            next_win = cfg_i.config_window_select;
        end else begin
            if (wr0) begin
                next_sen = reg_wdata_i[`WINDOWED_WATCHDOG_C0_SEN];
                if (ps_sw) begin
                    next_ps = reg_wdata_i[`WINDOWED_WATCHDOG_C0_PS_MSB:`WINDOWED_WATCHDOG_C0_PS_LSB];
                end
            end
            if (wr1) begin
                if (cs_sw) begin
                    next_cs = reg_wdata_i[`WINDOWED_WATCHDOG_C1_CS_MSB:`WINDOWED_WATCHDOG_C1_CS_LSB];
                end
                if (win_sw) begin
                    next_win = reg_wdata_i[`WINDOWED_WATCHDOG_C1_WIN_MSB:`WINDOWED_WATCHDOG_C1_WIN_LSB];
                end
            end
        end
        // arming wins over the clear that consumes it in the same cycle
        if (rd0) begin
            next_armed = 1'b1;
        end else if (clr_evt) begin
            next_armed = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            loaded <= 1'b0;
            ps <= `WINDOWED_WATCHDOG_PS_DEFAULT;
            software_enable <= 1'b0;
            cs <= `WINDOWED_WATCHDOG_CS_DEFAULT;
            win <= `WINDOWED_WATCHDOG_WIN_OPEN;
            armed <= 1'b0;
        end else begin
            loaded <= next_loaded;
            ps <= next_ps;
            software_enable <= next_sen;
            cs <= next_cs;
            win <= next_win;
            armed <= next_armed;
        end
    end

    // ----------------------------------------------------------------
    // watchdog counter, window and time-out
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt;      // prescaled count
    logic [CNT_W-1:0] next_cnt;
    logic sleep_q;              // sleep level one cycle ago
    logic active;               // watchdog running
    logic tick;                 // selected watchdog clock edge
    logic [4:0] winval;         // window position in the period
    logic closed;               // window currently closed
    logic windowed;             // windowed operation selected
    logic viol;                 // window violation
    logic clr_all;              // any clearing condition
    logic timeout;              // period elapsed
    logic next_rst;
    logic next_wake;
    windowed_watchdog_pkg::windowed_watchdog_flags_s next_flags;

    // operating mode decision
    always_comb begin
        case (cfg_i.enable_configuration)
            windowed_watchdog_pkg::WINDOWED_WATCHDOG_MODE_ON: active = 1'b1;
            windowed_watchdog_pkg::WINDOWED_WATCHDOG_MODE_NOSLP: active = !sleep_i;
            windowed_watchdog_pkg::WINDOWED_WATCHDOG_MODE_SW: active = software_enable;
            default: active = 1'b0;
        endcase
    end

    // clock pick; reserved codes give no ticks at all
    always_comb begin
        if (cs == `WINDOWED_WATCHDOG_CS_LF) begin
            tick = osc_edge[0];
        end else if (cs == `WINDOWED_WATCHDOG_CS_MF) begin
            tick = osc_edge[1];
        end else if (cs == `WINDOWED_WATCHDOG_CS_SECONDARY_OSC) begin
            tick = osc_edge[2] && secondary_osc_ready;
        end else begin
            tick = 1'b0;
        end
    end

    // window position from the five top bits of the period
    assign winval = windowed_watchdog_winval(cnt, ps);
    assign closed = (win != `WINDOWED_WATCHDOG_WIN_OPEN) && (winval < {~win, 2'b00});
    assign windowed = (win != `WINDOWED_WATCHDOG_WIN_OPEN);

    // clear instructions only execute while the core is awake
    assign clr_evt = clear_watchdog_instruction_i && active && !sleep_i && loaded;
    assign viol = clr_evt && windowed && (!armed || closed);

    // divider changes of the core clock have no path in here at all
    assign clr_all = !active
                  || (sleep_i && !sleep_q)
                  || (!sleep_i && sleep_q)
                  || ost_running_i
                  || wr0 || wr1
                  || (clr_evt && !viol);

    assign timeout = active && tick && !clr_all && (cnt == windowed_watchdog_term(ps));

    // counter and event next values
    always_comb begin
        next_cnt = cnt;
        if (clr_all || timeout) begin
            next_cnt = '0;
        end else if (tick) begin
            next_cnt = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        next_rst = (timeout && !sleep_i) || viol;
        next_wake = timeout && sleep_i;
        // a new event beats the clear in the same cycle
        next_flags.timeout_flag = next_wake || (flags_o.timeout_flag && !flags_clear_i);
        next_flags.powerdown_flag = next_wake || (flags_o.powerdown_flag && !flags_clear_i);
        next_flags.watchdog_reset_flag = next_rst || (flags_o.watchdog_reset_flag && !flags_clear_i);
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= '0;
            sleep_q <= 1'b0;
            wdt_reset_o <= 1'b0;
            wake_o <= 1'b0;
            flags_o <= '0;
        end else begin
            cnt <= next_cnt;
            sleep_q <= sleep_i;
            wdt_reset_o <= next_rst;
            wake_o <= next_wake;
            flags_o <= next_flags;
        end
    end

    // ----------------------------------------------------------------
    // read data, valid only in the cycle after the read strobe
    // ----------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (reg_re_i) begin
            if (reg_addr_i == `WINDOWED_WATCHDOG_OFS_CTRL0) begin
                next_rdata = {2'b00, ps, software_enable};
            end else if (reg_addr_i == `WINDOWED_WATCHDOG_OFS_CTRL1) begin
                next_rdata = {1'b0, cs, 1'b0, win};
            end else if (reg_addr_i == `WINDOWED_WATCHDOG_OFS_STATUS) begin
                next_rdata = {winval, armed, 2'b00};
            end else begin
                next_rdata = 8'h00; // unmapped reads as zero
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking windowed_watchdog_cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    a_off_hold: assert property ((cfg_i.enable_configuration == windowed_watchdog_pkg::WINDOWED_WATCHDOG_MODE_OFF) |=> (cnt == '0))
        else $error("counter not held while off");
    a_sw_hold: assert property ((cfg_i.enable_configuration == windowed_watchdog_pkg::WINDOWED_WATCHDOG_MODE_SW) && !software_enable |=> (cnt == '0))
        else $error("counter runs with software enable low");
    a_sleep_entry: assert property ($rose(sleep_i) |=> (cnt == '0))
        else $error("counter not cleared on sleep entry");
    a_sleep_exit: assert property ($fell(sleep_i) |=> (cnt == '0))
        else $error("counter not cleared on sleep exit");
    a_ost_hold: assert property (ost_running_i [*2] |-> (cnt == '0))
        else $error("counter moved during start-up timer");
    a_write_clear: assert property ((wr0 || wr1) |=> (cnt == '0))
        else $error("register write did not clear counter");
    a_arm_read: assert property (rd0 |=> armed)
        else $error("read of control zero did not arm");
    a_unarmed_viol: assert property (clr_evt && windowed && !armed |=> wdt_reset_o ##1 !wdt_reset_o)
        else $error("unarmed clear did not reset once");
    a_closed_viol: assert property (clr_evt && closed |=> wdt_reset_o && flags_o.watchdog_reset_flag)
        else $error("clear in closed window did not reset");
    a_sleep_wake: assert property (timeout && sleep_i |=> wake_o && !wdt_reset_o)
        else $error("sleep time-out did not wake cleanly");
    a_wake_flags: assert property (wake_o |-> flags_o.timeout_flag && flags_o.powerdown_flag)
        else $error("status flags missing after wake");
    a_rsvd_zero: assert property (reg_re_i && (reg_addr_i <= `WINDOWED_WATCHDOG_OFS_CTRL1) |=> (reg_rdata_o[7] == 1'b0))
        else $error("unimplemented bit read nonzero");
    a_secondary_osc_gate: assert property ((cs == `WINDOWED_WATCHDOG_CS_SECONDARY_OSC) && !secondary_osc_ready |-> !tick)
        else $error("secondary oscillator ticked before start-up");

endmodule : windowed_watchdog_top

// ==== test/windowed_watchdog_testbench.sv ====
// self-checking bench for the windowed watchdog: register port, time-out, window, sleep
// assumes windowed_watchdog_pkg and the defines header are compiled first; design assertions sit inside it
`timescale 1ns/10ps

module testbench;
    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    windowed_watchdog_pkg::windowed_watchdog_cfg_s cfg_i = '0;
    logic [4:0] cyc = 5'h00; // divider for the slow oscillators
    logic sleep_i = 1'b0;
    logic ost_running_i = 1'b0;
    logic clear_watchdog_instruction_i = 1'b0;
    logic flags_clear_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic wdt_reset_o;
    logic wake_o;
    windowed_watchdog_pkg::windowed_watchdog_flags_s flags_o;
    int failures = 0;
    int checked = 0;
    logic [7:0] v; // last read value
    int n; // cycles waited

    // ----------------------------------------------------------------
    // clock and oscillators
    // ----------------------------------------------------------------
    // oscillator ticks every 8, 16 and 32 cycles, well above the sync limit
    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 5'h01;
    end

    // small start-up count keeps the secondary oscillator test short
    windowed_watchdog_top #(.SECONDARY_OSC_STARTUP(4)) uut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i),
        .lfosc_clk_i(cyc[2]), .mfosc_clk_i(cyc[3]), .secondary_osc_clk_i(cyc[4]),
        .sleep_i(sleep_i), .ost_running_i(ost_running_i),
        .clear_watchdog_instruction_i(clear_watchdog_instruction_i), .flags_clear_i(flags_clear_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .wdt_reset_o(wdt_reset_o), .wake_o(wake_o), .flags_o(flags_o)
    );

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task summarize;
        $display("compares=%0d mismatches=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // reset with a new set of configuration words, two edges of settling
    task do_reset(input logic [12:0] c);
        @(posedge sys_clk_i);
        rstn_i <= 1'b0;
        cfg_i <= c;
        repeat (6) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
    endtask : do_reset

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_we_i <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_re_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd

    task rdc(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask : rdc

    // one-cycle clear instruction, returns just after the answering edge
    task clr;
        @(posedge sys_clk_i);
        clear_watchdog_instruction_i <= 1'b1;
        @(posedge sys_clk_i);
        clear_watchdog_instruction_i <= 1'b0;
        #1;
    endtask : clr

    // bounded wait for the reset pulse (sel 0) or the wake pulse (sel 1)
    task wait_hi(input int sel, input int max, output int cnt);
        cnt = 0;
        while (((sel == 0) ? wdt_reset_o : wake_o) !== 1'b1 && cnt < max) begin
            @(posedge sys_clk_i);
            #1;
            cnt++;
        end
    endtask : wait_hi

    // poll the status register until the counter stands in the open part of a 12.5 percent window
    task wait_open;
        v = 8'h00;
        n = 0;
        while (v[7:3] !== 5'h1C && n < 300) begin
            rd(4'h2, v);
            n++;
        end
    endtask : wait_open

    // a mid-period rewrite restarts the count, so an uncleared counter fires a full period after the rewrite
    task tmo(input logic [7:0] c1, input logic [7:0] c0, input int p, input int k, input bit fire);
        int cnt;
        wr(4'h1, c1);
        repeat (100) @(posedge sys_clk_i);
        wr(4'h0, c0);
        wait_hi(0, (k + 8) * p + 20, cnt);
        if (fire) begin
            check(8'(cnt >= (k - 1) * p && cnt <= (k + 1) * p + 8), 8'h01);
        end else begin
            check(8'(cnt == (k + 8) * p + 20), 8'h01);
        end
    endtask : tmo

    // ----------------------------------------------------------------
    // watchdog against a hang
    // ----------------------------------------------------------------
    initial begin
        #400000;
        failures++;
        summarize();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        // software mode, all fields writable
        do_reset({2'b01, 5'h1F, 3'h7, 3'h7});
        rdc(4'h0, 8'h16);
        rdc(4'h1, 8'h07);
        wr(4'h0, 8'hFF);
        rdc(4'h0, 8'h3F);
        wr(4'h1, 8'hFF);
        rdc(4'h1, 8'h77);
        rdc(4'hF, 8'h00);
        // clock sources, ratios and the software enable
        tmo(8'h07, 8'h01, 8, 32, 1'b1);
        tmo(8'h17, 8'h01, 16, 32, 1'b1);
        tmo(8'h27, 8'h01, 32, 32, 1'b1);
        tmo(8'h37, 8'h01, 8, 32, 1'b0);
        tmo(8'h07, 8'h03, 8, 64, 1'b1);
        tmo(8'h07, 8'h27, 8, 32, 1'b1);
        tmo(8'h07, 8'h00, 8, 32, 1'b0);
        // start-up timer holds the counter; enabled at the shortest ratio it would fire in 256 cycles
        ost_running_i <= 1'b1;
        wr(4'h0, 8'h01);
        wait_hi(0, 400, n);
        check(8'(n == 400), 8'h01);
        ost_running_i <= 1'b0;
        // window of 12.5 percent: armed but closed, unarmed but open, then armed inside the open part
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h01);
        rd(4'h0, v);
        clr();
        check({7'h00, wdt_reset_o}, 8'h01);
        check({7'h00, flags_o.watchdog_reset_flag}, 8'h01);
        // that clear used up the arming; a violation does not clear the counter
        wait_open();
        clr();
        check({7'h00, wdt_reset_o}, 8'h01);
        wr(4'h0, 8'h01);
        wait_open();
        rd(4'h0, v);
        clr();
        check({7'h00, wdt_reset_o}, 8'h00);
        rd(4'h2, v);
        check({7'h00, v[2]}, 8'h00);
        check(8'(v[7:3] <= 5'h01), 8'h01);
        // time-out in sleep wakes instead of resetting
        wr(4'h1, 8'h07);
        repeat (150) @(posedge sys_clk_i);
        sleep_i <= 1'b1;
        wait_hi(1, 400, n);
        check(8'(n >= 248 && n <= 272), 8'h01);
        check({7'h00, wdt_reset_o}, 8'h00);
        @(posedge sys_clk_i);
        #1;
        check({6'h00, flags_o.timeout_flag, flags_o.powerdown_flag}, 8'h03);
        sleep_i <= 1'b0;
        @(posedge sys_clk_i);
        flags_clear_i <= 1'b1;
        @(posedge sys_clk_i);
        flags_clear_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        check({5'h00, flags_o}, 8'h00);
        // on while awake, off in sleep; configured fields are read-only
        do_reset({2'b10, 5'h00, 3'h7, 3'h5});
        rdc(4'h0, 8'h00);
        wr(4'h0, 8'h3F);
        rdc(4'h0, 8'h01);
        rdc(4'h1, 8'h05);
        wr(4'h1, 8'h07);
        rdc(4'h1, 8'h05);
        tmo(8'h05, 8'h00, 8, 32, 1'b1);
        sleep_i <= 1'b1;
        wait_hi(1, 400, n);
        check(8'(n == 400), 8'h01);
        sleep_i <= 1'b0;
        // always off: software enable and shortest ratio must still give no reset
        do_reset({2'b00, 5'h1F, 3'h7, 3'h7});
        wr(4'h0, 8'h01);
        wait_hi(0, 400, n);
        check(8'(n == 400), 8'h01);
        repeat (4) @(posedge sys_clk_i);
        summarize();
    end
endmodule : testbench
